// ---- common/high_port_regs.vh ----
// register offsets, reset values and field positions for the high port bank
`ifndef HIGH_PORT_REGS_VH
`define HIGH_PORT_REGS_VH
`define PORT4_DRIVE_SELECT_ADDR 8'h9c
`define PORT5_DRIVE_SELECT_ADDR 8'h9d
`define PORT6_DRIVE_SELECT_ADDR 8'h9e
`define PORT7_DRIVE_SELECT_ADDR 8'h9f
`define PORT4_LATCH_ADDR        8'hc8
`define PORT5_LATCH_ADDR        8'hd8
`define PORT6_LATCH_ADDR        8'he8
`define PORT7_LATCH_ADDR        8'hf8
`define CROSSBAR_TWO_ADDR       8'he3
`define DRIVE_SELECT_RESET      8'h00
`define LATCH_RESET             8'hff
`define CROSSBAR_TWO_RESET      8'h00
`define PULLUP_DISABLE_BIT      7
`define LOW_PORT_MEMIF_BIT      5
`define STROBE_WR_BIT           7
`define STROBE_RD_BIT           6
`define STROBE_ALE_BIT          5
`endif

// ---- core/pin_sync.v ----
// two flip-flop synchroniser for a group of pad inputs
`default_nettype none
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             ref_clk_i,
  input  wire             reset_n_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      meta_q   <= {WIDTH{1'b1}};
      stable_q <= {WIDTH{1'b1}};
    end else begin
      meta_q   <= async_i;
      stable_q <= meta_q;
    end
  end
  assign sync_o = stable_q;
endmodule // pin_sync
`default_nettype wire

// ---- core/pad_drive.v ----
// per-pin pad drive: value, enable and pullup from latch, mode and override
`default_nettype none
module pad_drive #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] latch_i,
  input  wire [WIDTH-1:0] push_pull_i,
  input  wire [WIDTH-1:0] force_od_i,
  input  wire [WIDTH-1:0] ovr_sel_i,
  input  wire [WIDTH-1:0] ovr_val_i,
  input  wire [WIDTH-1:0] ovr_hiz_i,
  input  wire             pullup_off_i,
  output wire [WIDTH-1:0] pad_out_o,
  output wire [WIDTH-1:0] pad_oe_o,
  output wire [WIDTH-1:0] pad_pu_o
);
  wire [WIDTH-1:0] val;
  wire [WIDTH-1:0] pp;
  wire [WIDTH-1:0] drive_low;
  // memory interface value replaces the latch during its cycle
  assign val = (ovr_sel_i & ovr_val_i) | (~ovr_sel_i & latch_i);
  // mode bit 1 is push-pull, forced open-drain wins
  assign pp = push_pull_i & ~force_od_i;
  assign drive_low = ~val & ~ovr_hiz_i;
  // push-pull drives both levels, open-drain only pulls low
  // external read releases data pins, mode left untouched
  assign pad_oe_o  = ~ovr_hiz_i & (pp | ~val);
  assign pad_out_o = val & ~drive_low;
  // pullup off globally or when this pin pulls itself low
  assign pad_pu_o  = {WIDTH{~pullup_off_i}} & ~drive_low;
endmodule // pad_drive
`default_nettype wire

// ---- core/high_port_gpio_bank.v ----
// gpio logic for high ports 4 to 7 with memory interface takeover
`include "high_port_regs.vh"
`default_nettype none
module high_port_gpio_bank #(
  parameter WIDTH = 8
) (
  input  wire             ref_clk_i,
  input  wire             reset_n_i,
  // register port: page already selected by the core
  input  wire [7:0]       reg_addr_i,
  input  wire             reg_wr_i,
  input  wire [7:0]       reg_wdata_i,
  input  wire             reg_rd_i,
  input  wire             reg_rmw_i,
  output reg  [7:0]       reg_rdata_o,
  // memory interface takeover
  input  wire             memif_active_i,
  input  wire             memif_read_i,
  input  wire             memif_muxed_i,
  input  wire [15:0]      memif_addr_i,
  input  wire [7:0]       memif_wdata_i,
  input  wire             memif_wr_n_i,
  input  wire             memif_rd_n_i,
  input  wire             memif_ale_i,
  input  wire             memif_ad_phase_i,
  output wire [7:0]       memif_rdata_o,
  // pins forced open-drain by routed peripherals
  input  wire [4*WIDTH-1:0] force_od_i,
  // pads
  input  wire [4*WIDTH-1:0] pad_in_i,
  output wire [4*WIDTH-1:0] pad_out_o,
  output wire [4*WIDTH-1:0] pad_oe_o,
  output wire [4*WIDTH-1:0] pad_pu_o,
  output wire               pullup_global_disable_o,
  output wire               low_port_memif_enable_o
);
  reg  [WIDTH-1:0]   port4_latch_q;
  reg  [WIDTH-1:0]   port5_latch_q;
  reg  [WIDTH-1:0]   port6_latch_q;
  reg  [WIDTH-1:0]   port7_latch_q;
  reg  [WIDTH-1:0]   port4_drive_select_q;
  reg  [WIDTH-1:0]   port5_drive_select_q;
  reg  [WIDTH-1:0]   port6_drive_select_q;
  reg  [WIDTH-1:0]   port7_drive_select_q;
  reg  [7:0]         crossbar_config_two_q;
  reg  [7:0]         rdata_d;
  reg  [4*WIDTH-1:0] ovr_sel;
  reg  [4*WIDTH-1:0] ovr_val;
  reg  [4*WIDTH-1:0] ovr_hiz;
  wire [4*WIDTH-1:0] pin_sync;
  wire [4*WIDTH-1:0] latch_all;
  wire [4*WIDTH-1:0] mode_all;
  wire [3:0]         reg_sel_w;

  // register indices produced by the address decoder
  localparam [3:0] SEL_NONE     = 4'h0;
  localparam [3:0] SEL_P4_LATCH = 4'h1;
  localparam [3:0] SEL_P5_LATCH = 4'h2;
  localparam [3:0] SEL_P6_LATCH = 4'h3;
  localparam [3:0] SEL_P7_LATCH = 4'h4;
  localparam [3:0] SEL_P4_DRIVE = 4'h5;
  localparam [3:0] SEL_P5_DRIVE = 4'h6;
  localparam [3:0] SEL_P6_DRIVE = 4'h7;
  localparam [3:0] SEL_P7_DRIVE = 4'h8;
  localparam [3:0] SEL_CROSSBAR = 4'h9;

  // one decoder for the write and the read path, so the two cannot drift apart
  function [3:0] reg_sel;
    input [7:0] addr;
    begin
      if (addr == `PORT4_LATCH_ADDR) begin
        reg_sel = SEL_P4_LATCH;
      end else if (addr == `PORT5_LATCH_ADDR) begin
        reg_sel = SEL_P5_LATCH;
      end else if (addr == `PORT6_LATCH_ADDR) begin
        reg_sel = SEL_P6_LATCH;
      end else if (addr == `PORT7_LATCH_ADDR) begin
        reg_sel = SEL_P7_LATCH;
      end else if (addr == `PORT4_DRIVE_SELECT_ADDR) begin
        reg_sel = SEL_P4_DRIVE;
      end else if (addr == `PORT5_DRIVE_SELECT_ADDR) begin
        reg_sel = SEL_P5_DRIVE;
      end else if (addr == `PORT6_DRIVE_SELECT_ADDR) begin
        reg_sel = SEL_P6_DRIVE;
      end else if (addr == `PORT7_DRIVE_SELECT_ADDR) begin
        reg_sel = SEL_P7_DRIVE;
      end else if (addr == `CROSSBAR_TWO_ADDR) begin
        reg_sel = SEL_CROSSBAR;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction

  // byte of a four-port vector; port 4 is byte 0
  function [WIDTH-1:0] port_byte;
    input [4*WIDTH-1:0] vec;
    input [1:0]         port;
    begin
      port_byte = vec[port*WIDTH +: WIDTH];
    end
  endfunction

  assign reg_sel_w = reg_sel(reg_addr_i);

  // one synchroniser per port keeps each byte's two stages beside its pads
  pin_sync #(.WIDTH(WIDTH)) u_sync4 (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (pad_in_i[WIDTH-1:0]),
    .sync_o    (pin_sync[WIDTH-1:0])
  );

  pin_sync #(.WIDTH(WIDTH)) u_sync5 (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (pad_in_i[2*WIDTH-1:WIDTH]),
    .sync_o    (pin_sync[2*WIDTH-1:WIDTH])
  );

  pin_sync #(.WIDTH(WIDTH)) u_sync6 (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (pad_in_i[3*WIDTH-1:2*WIDTH]),
    .sync_o    (pin_sync[3*WIDTH-1:2*WIDTH])
  );

  pin_sync #(.WIDTH(WIDTH)) u_sync7 (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (pad_in_i[4*WIDTH-1:3*WIDTH]),
    .sync_o    (pin_sync[4*WIDTH-1:3*WIDTH])
  );

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      port4_latch_q         <= `LATCH_RESET;
      port5_latch_q         <= `LATCH_RESET;
      port6_latch_q         <= `LATCH_RESET;
      port7_latch_q         <= `LATCH_RESET;
      port4_drive_select_q  <= `DRIVE_SELECT_RESET;
      port5_drive_select_q  <= `DRIVE_SELECT_RESET;
      port6_drive_select_q  <= `DRIVE_SELECT_RESET;
      port7_drive_select_q  <= `DRIVE_SELECT_RESET;
      crossbar_config_two_q <= `CROSSBAR_TWO_RESET;
    end else if (reg_wr_i) begin
      // latch writes reach the pads through pad_drive
      case (reg_sel_w)
        SEL_P4_LATCH: begin
          port4_latch_q <= reg_wdata_i;
        end
        SEL_P5_LATCH: begin
          port5_latch_q <= reg_wdata_i;
        end
        SEL_P6_LATCH: begin
          port6_latch_q <= reg_wdata_i;
        end
        SEL_P7_LATCH: begin
          port7_latch_q <= reg_wdata_i;
        end
        SEL_P4_DRIVE: begin
          port4_drive_select_q <= reg_wdata_i;
        end
        SEL_P5_DRIVE: begin
          port5_drive_select_q <= reg_wdata_i;
        end
        SEL_P6_DRIVE: begin
          port6_drive_select_q <= reg_wdata_i;
        end
        SEL_P7_DRIVE: begin
          port7_drive_select_q <= reg_wdata_i;
        end
        SEL_CROSSBAR: begin
          crossbar_config_two_q <= reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  assign latch_all = {port7_latch_q, port6_latch_q, port5_latch_q, port4_latch_q};
  assign mode_all  = {port7_drive_select_q, port6_drive_select_q,
                      port5_drive_select_q, port4_drive_select_q};

  // read-modify-write sees the latch, plain reads see the pins
  always @* begin
    rdata_d = 8'h00;
    case (reg_sel_w)
      SEL_P4_LATCH: begin
        rdata_d = reg_rmw_i ? port4_latch_q : port_byte(pin_sync, 2'h0);
      end
      SEL_P5_LATCH: begin
        rdata_d = reg_rmw_i ? port5_latch_q : port_byte(pin_sync, 2'h1);
      end
      SEL_P6_LATCH: begin
        rdata_d = reg_rmw_i ? port6_latch_q : port_byte(pin_sync, 2'h2);
      end
      SEL_P7_LATCH: begin
        rdata_d = reg_rmw_i ? port7_latch_q : port_byte(pin_sync, 2'h3);
      end
      SEL_P4_DRIVE: begin
        rdata_d = port4_drive_select_q;
      end
      SEL_P5_DRIVE: begin
        rdata_d = port5_drive_select_q;
      end
      SEL_P6_DRIVE: begin
        rdata_d = port6_drive_select_q;
      end
      SEL_P7_DRIVE: begin
        rdata_d = port7_drive_select_q;
      end
      SEL_CROSSBAR: begin
        rdata_d = crossbar_config_two_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // registered read data, held until the next read
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

  // takeover map; only active while a move instruction runs
  always @* begin
    ovr_sel = {4*WIDTH{1'b0}};
    ovr_val = {4*WIDTH{1'b0}};
    ovr_hiz = {4*WIDTH{1'b0}};
    if (memif_active_i) begin
      ovr_sel[`STROBE_WR_BIT]  = 1'b1;
      ovr_val[`STROBE_WR_BIT]  = memif_wr_n_i;
      ovr_sel[`STROBE_RD_BIT]  = 1'b1;
      ovr_val[`STROBE_RD_BIT]  = memif_rd_n_i;
      ovr_sel[`STROBE_ALE_BIT] = 1'b1;
      ovr_val[`STROBE_ALE_BIT] = memif_ale_i;
      ovr_sel[4*WIDTH-1:2*WIDTH] = {2*WIDTH{1'b1}};
      if (memif_muxed_i) begin
        ovr_val[3*WIDTH-1:2*WIDTH] = memif_addr_i[15:8];
        ovr_val[4*WIDTH-1:3*WIDTH] = memif_ad_phase_i ?
                                     memif_addr_i[7:0] : memif_wdata_i;
        // data bus released in the data phase of a read
        ovr_hiz[4*WIDTH-1:3*WIDTH] = {WIDTH{memif_read_i & ~memif_ad_phase_i}};
      end else begin
        ovr_sel[2*WIDTH-1:WIDTH] = {WIDTH{1'b1}};
        ovr_val[2*WIDTH-1:WIDTH] = memif_addr_i[15:8];
        ovr_val[3*WIDTH-1:2*WIDTH] = memif_addr_i[7:0];
        ovr_val[4*WIDTH-1:3*WIDTH] = memif_wdata_i;
        ovr_hiz[4*WIDTH-1:3*WIDTH] = {WIDTH{memif_read_i}};
      end
    end
  end

  // software is expected to keep this clear while memif uses high ports
  assign low_port_memif_enable_o = crossbar_config_two_q[`LOW_PORT_MEMIF_BIT];
  assign pullup_global_disable_o = crossbar_config_two_q[`PULLUP_DISABLE_BIT];
  // external read data comes from the synchronised data bus pins
  // the two stage latency means a read issued right after a bus turnaround sees old data
  assign memif_rdata_o = port_byte(pin_sync, 2'h3);

  // one pad driver per port; input use relies on open-drain with latch one
  pad_drive #(.WIDTH(WIDTH)) u_drive4 (
    .latch_i      (latch_all[WIDTH-1:0]),
    .push_pull_i  (mode_all[WIDTH-1:0]),
    .force_od_i   (force_od_i[WIDTH-1:0]),
    .ovr_sel_i    (ovr_sel[WIDTH-1:0]),
    .ovr_val_i    (ovr_val[WIDTH-1:0]),
    .ovr_hiz_i    (ovr_hiz[WIDTH-1:0]),
    .pullup_off_i (pullup_global_disable_o),
    .pad_out_o    (pad_out_o[WIDTH-1:0]),
    .pad_oe_o     (pad_oe_o[WIDTH-1:0]),
    .pad_pu_o     (pad_pu_o[WIDTH-1:0])
  );

  pad_drive #(.WIDTH(WIDTH)) u_drive5 (
    .latch_i      (latch_all[2*WIDTH-1:WIDTH]),
    .push_pull_i  (mode_all[2*WIDTH-1:WIDTH]),
    .force_od_i   (force_od_i[2*WIDTH-1:WIDTH]),
    .ovr_sel_i    (ovr_sel[2*WIDTH-1:WIDTH]),
    .ovr_val_i    (ovr_val[2*WIDTH-1:WIDTH]),
    .ovr_hiz_i    (ovr_hiz[2*WIDTH-1:WIDTH]),
    .pullup_off_i (pullup_global_disable_o),
    .pad_out_o    (pad_out_o[2*WIDTH-1:WIDTH]),
    .pad_oe_o     (pad_oe_o[2*WIDTH-1:WIDTH]),
    .pad_pu_o     (pad_pu_o[2*WIDTH-1:WIDTH])
  );

  pad_drive #(.WIDTH(WIDTH)) u_drive6 (
    .latch_i      (latch_all[3*WIDTH-1:2*WIDTH]),
    .push_pull_i  (mode_all[3*WIDTH-1:2*WIDTH]),
    .force_od_i   (force_od_i[3*WIDTH-1:2*WIDTH]),
    .ovr_sel_i    (ovr_sel[3*WIDTH-1:2*WIDTH]),
    .ovr_val_i    (ovr_val[3*WIDTH-1:2*WIDTH]),
    .ovr_hiz_i    (ovr_hiz[3*WIDTH-1:2*WIDTH]),
    .pullup_off_i (pullup_global_disable_o),
    .pad_out_o    (pad_out_o[3*WIDTH-1:2*WIDTH]),
    .pad_oe_o     (pad_oe_o[3*WIDTH-1:2*WIDTH]),
    .pad_pu_o     (pad_pu_o[3*WIDTH-1:2*WIDTH])
  );

  pad_drive #(.WIDTH(WIDTH)) u_drive7 (
    .latch_i      (latch_all[4*WIDTH-1:3*WIDTH]),
    .push_pull_i  (mode_all[4*WIDTH-1:3*WIDTH]),
    .force_od_i   (force_od_i[4*WIDTH-1:3*WIDTH]),
    .ovr_sel_i    (ovr_sel[4*WIDTH-1:3*WIDTH]),
    .ovr_val_i    (ovr_val[4*WIDTH-1:3*WIDTH]),
    .ovr_hiz_i    (ovr_hiz[4*WIDTH-1:3*WIDTH]),
    .pullup_off_i (pullup_global_disable_o),
    .pad_out_o    (pad_out_o[4*WIDTH-1:3*WIDTH]),
    .pad_oe_o     (pad_oe_o[4*WIDTH-1:3*WIDTH]),
    .pad_pu_o     (pad_pu_o[4*WIDTH-1:3*WIDTH])
  );
endmodule // high_port_gpio_bank
`default_nettype wire

// ---- tb/high_port_gpio_bank_sva.sv ----
// concurrent checks on the pads and register port of the high port bank
`default_nettype none
module high_port_gpio_bank_sva (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_rmw_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        memif_active_i,
  input wire logic        memif_read_i,
  input wire logic        memif_muxed_i,
  input wire logic [15:0] memif_addr_i,
  input wire logic        memif_wr_n_i,
  input wire logic        memif_rd_n_i,
  input wire logic        memif_ale_i,
  input wire logic [7:0]  memif_rdata_o,
  input wire logic [31:0] force_od_i,
  input wire logic [31:0] pad_out_o,
  input wire logic [31:0] pad_oe_o,
  input wire logic [31:0] pad_pu_o,
  input wire logic        pullup_global_disable_o
);
  timeunit 1ns / 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_RESET_PADS: assert property (disable iff (1'b0) !reset_n_i |=>
    pad_oe_o == '0 && pad_pu_o == 32'hffff_ffff) else $error("pads not idle after reset");
  AST_LOW_NO_PULLUP: assert property ((pad_oe_o & ~pad_out_o & pad_pu_o) == '0)
    else $error("pullup on a pin driven low");
  AST_PULLUP_DISABLE: assert property (pullup_global_disable_o |-> pad_pu_o == '0)
    else $error("pullup on while disabled");
  AST_FORCED_OD: assert property (!memif_active_i |->
    (force_od_i & pad_oe_o & pad_out_o) == '0) else $error("forced pin driven high");
  AST_STROBES: assert property (memif_active_i |->
    pad_out_o[7:5] == {memif_wr_n_i, memif_rd_n_i, memif_ale_i}) else $error("strobes wrong");
  AST_ADDR_P6: assert property (memif_active_i |-> pad_out_o[23:16] ==
    (memif_muxed_i ? memif_addr_i[15:8] : memif_addr_i[7:0])) else $error("port6 address");
  AST_READ_RELEASE: assert property (memif_active_i && memif_read_i && !memif_muxed_i |->
    pad_oe_o[31:24] == 8'h00) else $error("data bus driven during read");
  AST_PIN_READ: assert property (reg_rd_i && !reg_rmw_i && reg_addr_i == 8'hf8 |=>
    reg_rdata_o == $past(memif_rdata_o)) else $error("port7 read not pin level");
  COV_MEMIF_READ: cover property (memif_active_i && memif_read_i);
  COV_RMW_READ: cover property (reg_rd_i && reg_rmw_i);
  COV_PIN_READ: cover property (reg_rd_i && !reg_rmw_i && reg_addr_i == 8'hf8);
endmodule // high_port_gpio_bank_sva
bind high_port_gpio_bank high_port_gpio_bank_sva i_high_port_gpio_bank_sva (.*);
`default_nettype wire

// ---- tb/port_pins.sv ----
// pad wires: the bank's drivers, outside devices and floating lines
`default_nettype none
module port_pins (
  input  wire logic        ref_clk_i,
  input  wire logic [31:0] out_i,
  input  wire logic [31:0] oe_i,
  input  wire logic [31:0] pu_i,
  input  wire logic [31:0] ext_i,
  input  wire logic [31:0] ext_en_i,
  output wire logic [31:0] level_o
);
  timeunit 1ns / 1ns;
  logic [31:0] wander_q = '0;
  // an undriven pin without pullup wanders, so a stale level is never read as good
  always @(posedge ref_clk_i) wander_q <= ~wander_q;
  assign level_o = oe_i & out_i | ~oe_i & (ext_en_i & ext_i | ~ext_en_i & (pu_i | wander_q));
endmodule // port_pins
`default_nettype wire

// ---- tb/test_high_port_gpio_bank.sv ----
// self-checking bench: register and pad model against the high port bank
`default_nettype none
module test_high_port_gpio_bank;
  timeunit 1ns / 1ns;
  logic        ref_clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic        reg_rmw_i = 1'b0, memif_active_i = 1'b0, memif_read_i = 1'b0;
  logic        memif_muxed_i = 1'b0, memif_ad_phase_i = 1'b0, memif_ale_i = 1'b0;
  logic        memif_wr_n_i = 1'b1, memif_rd_n_i = 1'b1;
  logic        pullup_global_disable_o, low_port_memif_enable_o;
  logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, memif_wdata_i = 8'h00;
  logic [7:0]  reg_rdata_o, memif_rdata_o, xb = 8'h00;
  logic [7:0]  lat [4] = '{default: 8'hff};
  logic [7:0]  mode [4] = '{default: 8'h00};
  logic [15:0] memif_addr_i = 16'h0000;
  logic [31:0] force_od_i = '0, pad_in_i, pad_out_o, pad_oe_o, pad_pu_o, ext = '0, ext_en = '0;
  logic [31:0] seed = 32'h0000_001d, r;
  int          fail_count = 0, samples_checked = 0;
  localparam logic [7:0] ADDRS [10] = '{8'h9c, 8'h9d, 8'h9e, 8'h9f, 8'hc8, 8'hd8, 8'he8,
                                        8'hf8, 8'he3, 8'h00};
  high_port_gpio_bank i_high_port_gpio_bank (.*);
  port_pins i_port_pins (.ref_clk_i, .out_i(pad_out_o), .oe_i(pad_oe_o), .pu_i(pad_pu_o),
                         .ext_i(ext), .ext_en_i(ext_en), .level_o(pad_in_i));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    fail_count++;
    finish_test();
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] mval(int i);
    return i < 4 ? mode[i] : i < 8 ? lat[i - 4] : i == 8 ? xb : 8'h00;
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus access; on a read d is the expected data
  task automatic acc(int i, logic w, logic m, logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= ADDRS[i];
    reg_wdata_i <= d;
    {reg_wr_i, reg_rd_i, reg_rmw_i} <= {w, !w, m};
    @(posedge ref_clk_i);
    {reg_wr_i, reg_rd_i, reg_rmw_i} <= 3'b000;
    @(negedge ref_clk_i);
    if (!w) chk("rdata", reg_rdata_o, d);
    else if (i < 4) mode[i] = d;
    else if (i < 8) lat[i - 4] = d;
    else if (i == 8) xb = d;
  endtask
  task automatic check_pads();
    logic [31:0] l, oe;
    l = {lat[3], lat[2], lat[1], lat[0]};
    oe = ~l | ({mode[3], mode[2], mode[1], mode[0]} & ~force_od_i);
    chk("oe", pad_oe_o, oe);
    chk("out", pad_out_o & oe, l & oe);
    chk("pu", pad_pu_o & ~(oe & l), xb[7] ? '0 : ~oe);
    chk("xbar", {pullup_global_disable_o, low_port_memif_enable_o}, {xb[7], xb[5]});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(negedge ref_clk_i);
    check_pads();
    for (int i = 0; i < 10; i++) acc(i, 1'b0, 1'b1, mval(i));
    $display("reset test done");
    repeat (40) begin
      r = rnd();
      @(posedge ref_clk_i);
      force_od_i <= r;
      acc(r[3:0] % 10, 1'b1, 1'b0, r[15:8]);
      check_pads();
      acc(r[19:16] % 9, 1'b0, 1'b1, mval(r[19:16] % 9));
    end
    $display("config test done");
    @(posedge ref_clk_i);
    force_od_i <= '0;
    for (int k = 0; k < 4; k++) begin
      acc(k, 1'b1, 1'b0, 8'h00);
      acc(k + 4, 1'b1, 1'b0, 8'hff);
    end
    @(posedge ref_clk_i);
    ext <= rnd();
    ext_en <= '1;
    repeat (3) @(posedge ref_clk_i);
    for (int k = 4; k < 8; k++) begin
      acc(k, 1'b0, 1'b0, ext[8 * k - 32 +: 8]);
      acc(k, 1'b0, 1'b1, 8'hff);
    end
    chk("memif rdata", memif_rdata_o, ext[31:24]);
    $display("pin read test done");
    @(posedge ref_clk_i);
    ext_en <= '0;
    acc(8, 1'b1, 1'b0, xb & 8'hdf);
    acc(4, 1'b1, 1'b0, 8'h00);
    for (int k = 0; k < 4; k++) acc(k, 1'b1, 1'b0, 8'hff);
    for (int m = 0; m < 8; m++) begin
      r = rnd();
      @(posedge ref_clk_i);
      {memif_active_i, memif_read_i, memif_muxed_i} <= {1'b1, m[0], m[1]};
      {memif_addr_i, memif_wdata_i} <= r[23:0];
      {memif_wr_n_i, memif_rd_n_i, memif_ale_i} <= r[26:24];
      memif_ad_phase_i <= m[2];
      @(negedge ref_clk_i);
      chk("strobes", pad_out_o[7:5], r[26:24]);
      chk("port6", pad_out_o[23:16], m[1] ? r[23:16] : r[15:8]);
      if (!m[1]) chk("port5", pad_out_o[15:8], r[23:16]);
      if (m[0] && !(m[1] && m[2])) chk("port7 oe", pad_oe_o[31:24], 8'h00);
      else chk("port7", pad_out_o[31:24], (m[1] && m[2]) ? r[15:8] : r[7:0]);
      chk("mode kept", pad_oe_o[23:8], 16'hffff);
      @(posedge ref_clk_i);
      memif_active_i <= 1'b0;
      @(negedge ref_clk_i);
      check_pads();
    end
    $display("memif test done");
    finish_test();
  end
endmodule // test_high_port_gpio_bank
`default_nettype wire
